// ===== core/dssr_core.sv
// The implementer's own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/10ps

module dssr_core (
  input wire logic clock,
  input wire logic srst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Command sequencer side
  input wire logic cmd_start,
  input wire logic [1:0] cmd_drive_select,
  input wire logic cmd_is_sense,
  input wire logic cmd_physical_addr_flag,
  input wire logic cmd_finish,
  output logic recal_req,
  // Operation results
  input wire logic op_done,
  input wire logic op_is_rw,
  input wire logic [1:0] op_drive_select,
  input wire logic [5:0] op_error_code,
  input wire logic op_late_ack,
  input wire logic op_parity_err,
  input wire logic op_deleted_mark,
  input wire logic op_retried,
  input wire logic op_corrected,
  input wire logic [10:0] op_cylinder_number,
  input wire logic [3:0] op_head_number,
  input wire logic [5:0] op_sector_number,
  input wire logic [20:0] op_logical_sector,
  // Drive condition, one bit per drive
  input wire logic [3:0] unit_ready_flag,
  input wire logic [3:0] two_sided_flag,
  input wire logic [3:0] write_protect_flag,
  input wire logic [3:0] at_cylinder_zero_flag,
  input wire logic [3:0] disk_changed,
  // Host byte port
  input wire logic host_ack,
  output logic host_req,
  output logic [7:0] host_data_o,
  output logic host_data_oe,
  output logic host_parity_o,
  output logic command_status_phase,
  output logic host_out_dir,
  output logic controller_engaged,
  output logic final_msg
);

  dssr_pkg::dssr_state_t state_q;
  logic [2:0] byte_idx_q;
  logic [4:0] gap_cnt_q;
  logic [1:0] req_drive_q;
  logic sense_q;
  logic pa_q;
  logic [5:0] err_log_q [dssr_pkg::NUM_DRIVES];
  logic [10:0] cyl_q;
  logic [3:0] head_q;
  logic [5:0] sector_q;
  logic [20:0] lsn_q;
  logic fatal_q;
  logic parity_q;
  logic retried_q;
  logic corrected_q;
  logic [3:0] nd_pending_q;
  logic nd_report_q;
  logic parity_en_q;
  logic [7:0] byte_d;
  logic [5:0] op_code;
  logic [1:0] db;
  logic ack_edge;
  logic wb_hit;
  logic status_done;

  // Codes other blocks may leave at zero are derived here, stored code has priority
  always_comb
  begin
    if (op_error_code != dssr_pkg::EC_NONE)
      op_code = op_error_code;
    else if (op_late_ack)
      op_code = dssr_pkg::EC_DATA_OVERRUN;
    else if (op_parity_err)
      op_code = dssr_pkg::EC_DATA_PARITY;
    else if (op_deleted_mark)
      op_code = dssr_pkg::EC_DELETED_DATA;
    else
      op_code = dssr_pkg::EC_NONE;
  end

  // Per-drive error log; sense never writes it, so a sense keeps what it reports
  genvar g;
  generate
    for (g = 0; g < dssr_pkg::NUM_DRIVES; g++)
    begin : g_log
      always_ff @(posedge clock)
      begin
        if (srst)
          err_log_q[g] <= dssr_pkg::EC_NONE;
        else if (op_done && op_drive_select == 2'(g))
          err_log_q[g] <= op_code;
      end
    end
  endgenerate

  // Address of the most recent read/write operation on any drive
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      cyl_q <= 11'h000;
      head_q <= 4'h0;
      sector_q <= 6'h00;
      lsn_q <= 21'h000000;
    end
    else if (op_done && op_is_rw)
    begin
      cyl_q <= op_cylinder_number;
      head_q <= op_head_number;
      sector_q <= op_sector_number;
      lsn_q <= op_logical_sector;
    end
  end

  // Outcome flags of the last operation
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      fatal_q <= 1'b0;
      retried_q <= 1'b0;
      corrected_q <= 1'b0;
    end
    else if (op_done)
    begin
      fatal_q <= (op_code != dssr_pkg::EC_NONE);
      retried_q <= op_retried;
      corrected_q <= op_corrected;
    end
  end

  // Parity flag is sticky until a status has carried it; a new error wins the clear
  always_ff @(posedge clock)
  begin
    if (srst)
      parity_q <= 1'b0;
    else if (op_done && op_parity_err)
      parity_q <= 1'b1;
    else if (status_done)
      parity_q <= 1'b0;
  end

  // New diskette: pending per floppy until the next command to it or a clear written to the control register
  generate
    for (g = 0; g < dssr_pkg::NUM_DRIVES; g++)
    begin : g_nd
      always_ff @(posedge clock)
      begin
        if (srst)
          nd_pending_q[g] <= 1'b0;
        else if (disk_changed[g] && g >= (1 << dssr_pkg::DRV_FLOPPY_BIT))
          nd_pending_q[g] <= 1'b1;
        else if (cmd_start && cmd_drive_select == 2'(g))
          nd_pending_q[g] <= 1'b0;
        else if (wb_hit && wb_we_i && wb_adr_i == dssr_pkg::REG_CTRL && wb_sel_i[1]
                 && wb_dat_i[dssr_pkg::CTRL_ND_CLEAR + g])
          nd_pending_q[g] <= 1'b0;
      end
    end
  endgenerate

  // Command capture, new-diskette report and automatic recalibration
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      req_drive_q <= 2'h0;
      sense_q <= 1'b0;
      pa_q <= 1'b0;
      nd_report_q <= 1'b0;
      recal_req <= 1'b0;
    end
    else
    begin
      recal_req <= 1'b0;
      if (cmd_start)
      begin
        req_drive_q <= cmd_drive_select;
        sense_q <= cmd_is_sense;
        pa_q <= cmd_physical_addr_flag;
        nd_report_q <= nd_pending_q[cmd_drive_select];
        recal_req <= nd_pending_q[cmd_drive_select];
      end
    end
  end

  // Byte to present for the current state and index
  always_comb
  begin
    db = req_drive_q;
    byte_d = 8'h00;
    if (state_q == dssr_pkg::DSSR_DATA_REQ || state_q == dssr_pkg::DSSR_DATA_REL)
    begin
      case (byte_idx_q)
        3'h0: byte_d = {2'b00, err_log_q[db]};
        3'h1: byte_d = pa_q ? {1'b0, db, cyl_q[10], head_q}
                            : {1'b0, db, lsn_q[20:16]};
        3'h2: byte_d = pa_q ? {cyl_q[9:8], sector_q} : lsn_q[15:8];
        default: byte_d = pa_q ? cyl_q[7:0] : lsn_q[7:0];
      endcase
    end
    else if (byte_idx_q == 3'h0)
      byte_d = {1'b0, db, 3'b000, fatal_q, parity_q};
    else
      byte_d = {1'b0, at_cylinder_zero_flag[db], write_protect_flag[db],
                two_sided_flag[db], unit_ready_flag[db], retried_q, corrected_q,
                nd_report_q};
  end

  localparam logic [2:0] STATUS_LAST = dssr_pkg::STATUS_BYTES - 3'h1;
  localparam logic [2:0] SENSE_LAST = dssr_pkg::SENSE_BYTES - 3'h1;
  localparam logic [4:0] GAP_LAST = 5'(dssr_pkg::PHASE_GAP_CYC - 1);

  assign ack_edge = host_ack;
  assign status_done = (state_q == dssr_pkg::DSSR_STAT_REQ) && ack_edge
                       && (byte_idx_q == STATUS_LAST);

  // Transfer sequencer: request, wait for acknowledge, then for its release except after the last status byte
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state_q <= dssr_pkg::DSSR_IDLE;
      byte_idx_q <= 3'h0;
      gap_cnt_q <= 5'h00;
    end
    else
    begin
      case (state_q)
        dssr_pkg::DSSR_IDLE:
        begin
          byte_idx_q <= 3'h0;
          gap_cnt_q <= 5'h00;
          if (cmd_finish)
            state_q <= sense_q ? dssr_pkg::DSSR_DATA_REQ : dssr_pkg::DSSR_GAP;
        end
        dssr_pkg::DSSR_DATA_REQ:
          if (ack_edge)
            state_q <= dssr_pkg::DSSR_DATA_REL;
        dssr_pkg::DSSR_DATA_REL:
          if (!host_ack)
          begin
            if (byte_idx_q == SENSE_LAST)
            begin
              byte_idx_q <= 3'h0;
              state_q <= dssr_pkg::DSSR_GAP;
            end
            else
            begin
              byte_idx_q <= byte_idx_q + 3'h1;
              state_q <= dssr_pkg::DSSR_DATA_REQ;
            end
          end
        dssr_pkg::DSSR_GAP:
          // Phase stays low long enough for the host to see the switch to status
          if (gap_cnt_q == GAP_LAST)
            state_q <= dssr_pkg::DSSR_STAT_REQ;
          else
            gap_cnt_q <= gap_cnt_q + 5'h01;
        dssr_pkg::DSSR_STAT_REQ:
          if (ack_edge)
          begin
            if (byte_idx_q == STATUS_LAST)
              state_q <= dssr_pkg::DSSR_IDLE;
            else
              state_q <= dssr_pkg::DSSR_STAT_REL;
          end
        dssr_pkg::DSSR_STAT_REL:
          if (!host_ack)
          begin
            byte_idx_q <= byte_idx_q + 3'h1;
            state_q <= dssr_pkg::DSSR_STAT_REQ;
          end
        default:
          state_q <= dssr_pkg::DSSR_IDLE;
      endcase
    end
  end

  // Data byte is registered and takes its new value on the same edge as the request rises
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      host_data_o <= 8'h00;
      host_parity_o <= 1'b0;
    end
    else
    begin
      host_data_o <= byte_d;
      host_parity_o <= parity_en_q & ~(^byte_d);
    end
  end

  logic req_arm_q;
  // Request waits one cycle after entering a request state so it rises on the edge that loads the new registered byte
  always_ff @(posedge clock)
  begin
    if (srst)
      req_arm_q <= 1'b0;
    else
      req_arm_q <= (state_q == dssr_pkg::DSSR_DATA_REQ || state_q == dssr_pkg::DSSR_STAT_REQ)
                   && !ack_edge;
  end

  assign host_req = req_arm_q && (state_q == dssr_pkg::DSSR_DATA_REQ
                                  || state_q == dssr_pkg::DSSR_STAT_REQ);
  assign host_data_oe = (state_q != dssr_pkg::DSSR_IDLE) && (state_q != dssr_pkg::DSSR_GAP);
  assign host_out_dir = (state_q != dssr_pkg::DSSR_IDLE);
  assign controller_engaged = (state_q != dssr_pkg::DSSR_IDLE);
  assign command_status_phase = (state_q == dssr_pkg::DSSR_STAT_REQ)
                                || (state_q == dssr_pkg::DSSR_STAT_REL);
  assign final_msg = command_status_phase && (byte_idx_q == STATUS_LAST);

  // Wishbone slave: one wait state, unmapped offsets read zero and ignore writes
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_ff @(posedge clock)
  begin
    if (srst)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_hit;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      parity_en_q <= 1'b0;
    else if (wb_hit && wb_we_i && wb_adr_i == dssr_pkg::REG_CTRL && wb_sel_i[0])
      parity_en_q <= wb_dat_i[dssr_pkg::CTRL_PARITY_EN];
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      wb_dat_o <= 32'h00000000;
    else if (wb_hit && !wb_we_i)
    begin
      case (wb_adr_i)
        dssr_pkg::REG_CTRL:
          wb_dat_o <= {20'h00000, nd_pending_q, 7'h00, parity_en_q};
        dssr_pkg::REG_ERR_LOG:
          wb_dat_o <= {2'b00, err_log_q[3], 2'b00, err_log_q[2],
                       2'b00, err_log_q[1], 2'b00, err_log_q[0]};
        dssr_pkg::REG_LAST_ADDR:
          wb_dat_o <= {11'h000, cyl_q, head_q, sector_q};
        dssr_pkg::REG_STATE:
          wb_dat_o <= {16'h0000, 1'b0, state_q, 1'b0, byte_idx_q,
                       2'b00, req_drive_q, corrected_q, retried_q, parity_q, fatal_q};
        default:
          wb_dat_o <= 32'h00000000;
      endcase
    end
  end

endmodule

// ===== include/dssr_pkg.sv
package dssr_pkg;

  // Error codes reported in the first sense byte
  localparam logic [5:0] EC_NONE = 6'h00;
  localparam logic [5:0] EC_NO_INDEX = 6'h01;
  localparam logic [5:0] EC_NO_SEEK_DONE = 6'h02;
  localparam logic [5:0] EC_WRITE_FAULT = 6'h03;
  localparam logic [5:0] EC_NOT_READY = 6'h04;
  localparam logic [5:0] EC_NO_TRACK0 = 6'h06;
  localparam logic [5:0] EC_DATA_CRC = 6'h11;
  localparam logic [5:0] EC_NO_ID_MARK = 6'h12;
  localparam logic [5:0] EC_NO_DATA_MARK = 6'h13;
  localparam logic [5:0] EC_SECTOR_ID = 6'h14;
  localparam logic [5:0] EC_POSITIONING = 6'h15;
  localparam logic [5:0] EC_DATA_OVERRUN = 6'h16;
  localparam logic [5:0] EC_WRITE_PROT = 6'h17;
  localparam logic [5:0] EC_DELETED_DATA = 6'h1b;
  localparam logic [5:0] EC_SECTOR_LEN = 6'h1c;
  localparam logic [5:0] EC_HEAD_SELECT = 6'h1d;
  localparam logic [5:0] EC_DENSITY = 6'h1e;
  localparam logic [5:0] EC_DATA_PARITY = 6'h1f;
  localparam logic [5:0] EC_COMMAND = 6'h20;
  localparam logic [5:0] EC_LOGICAL_ADDR = 6'h21;
  localparam logic [5:0] EC_SECTOR_ADDR = 6'h22;
  localparam logic [5:0] EC_HEAD_ADDR = 6'h23;
  localparam logic [5:0] EC_CYL_ADDR = 6'h24;
  localparam logic [5:0] EC_BUFFER = 6'h25;
  localparam logic [5:0] EC_DISK_OVERRUN = 6'h27;
  localparam logic [5:0] EC_CMD_PARITY = 6'h28;
  localparam logic [5:0] EC_DRIVE_TYPE = 6'h31;
  localparam logic [5:0] EC_ILLEGAL_STATE = 6'h32;
  localparam logic [5:0] EC_TIMEOUT_1 = 6'h33;
  localparam logic [5:0] EC_TIMEOUT_3 = 6'h35;

  // Drive numbering: bit 1 of the drive select marks a floppy
  localparam int DRV_FLOPPY_BIT = 1;
  localparam int NUM_DRIVES = 4;
  localparam logic [2:0] SENSE_BYTES = 3'h4;
  localparam logic [2:0] STATUS_BYTES = 3'h2;

  // Register map, byte addresses on the Wishbone slave
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ERR_LOG = 4'h4;
  localparam logic [3:0] REG_LAST_ADDR = 4'h8;
  localparam logic [3:0] REG_STATE = 4'hc;
  localparam int CTRL_PARITY_EN = 0;
  localparam int CTRL_ND_CLEAR = 8;

  // Command/status phase drops for at least this long between data and status
  localparam int CLK_PERIOD_NS = 50;
  localparam int PHASE_GAP_NS = 1000;
  localparam int PHASE_GAP_CYC = (PHASE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    DSSR_IDLE,
    DSSR_DATA_REQ,
    DSSR_DATA_REL,
    DSSR_GAP,
    DSSR_STAT_REQ,
    DSSR_STAT_REL
  } dssr_state_t;

endpackage

// ===== verif/disk_sense_status_report_test.sv
`timescale 1ns/10ps
module disk_sense_status_report_test;
  logic clock, srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, cmd_start, cmd_is_sense;
  logic cmd_physical_addr_flag, cmd_finish, recal_req, op_done, op_is_rw, op_late_ack;
  logic op_parity_err, op_deleted_mark, op_retried, op_corrected, host_ack, host_req;
  logic host_data_oe, host_parity_o, command_status_phase, host_out_dir, final_msg;
  logic controller_engaged, seen_q;
  logic [1:0] cmd_drive_select, op_drive_select;
  logic [3:0] wb_adr_i, wb_sel_i, op_head_number, unit_ready_flag, two_sided_flag, slow;
  logic [3:0] write_protect_flag, at_cylinder_zero_flag, disk_changed;
  logic [5:0] op_error_code, op_sector_number;
  logic [7:0] host_data_o;
  logic [10:0] op_cylinder_number;
  logic [20:0] op_logical_sector;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  int err_count = 0;
  int cmp_count = 0;
  dssr_core dut (.clock, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .cmd_start, .cmd_drive_select, .cmd_is_sense,
    .cmd_physical_addr_flag, .cmd_finish, .recal_req, .op_done, .op_is_rw, .op_drive_select,
    .op_error_code, .op_late_ack, .op_parity_err, .op_deleted_mark, .op_retried,
    .op_corrected, .op_cylinder_number, .op_head_number, .op_sector_number,
    .op_logical_sector, .unit_ready_flag, .two_sided_flag, .write_protect_flag,
    .at_cylinder_zero_flag, .disk_changed, .host_ack, .host_req, .host_data_o,
    .host_data_oe, .host_parity_o, .command_status_phase, .host_out_dir,
    .controller_engaged, .final_msg);
  dssr_host_model host (.clock, .srst, .slow, .host_req, .host_data_o, .host_parity_o,
    .host_ack);
  always #25 clock = ~clock;
  always @(posedge clock)
    if (recal_req === 1'h1)
      seen_q <= 1'h1;
  task chk(input string s, input logic [31:0] g, e);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task stop_test;
    if (err_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task wb(input logic w, input logic [3:0] a);
    @(posedge clock);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, w, a, 4'h1, 32'h1};
    @(posedge clock);
    // Only the watchdog ends a wait for the acknowledge
    while (wb_ack_o !== 1'h1)
      @(posedge clock);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    @(posedge clock);
  endtask
  task run(input logic [1:0] d, input logic s, a, o);
    int i;
    host.n = 0;
    @(posedge clock);
    {cmd_start, cmd_drive_select, cmd_is_sense, cmd_physical_addr_flag} <= {1'h1, d, s, a};
    @(posedge clock);
    {cmd_start, op_done} <= {1'h0, o};
    @(posedge clock);
    {op_done, cmd_finish} <= 2'h1;
    @(posedge clock);
    cmd_finish <= 1'h0;
    @(posedge clock);
    for (i = 0; i < 500 && controller_engaged !== 1'h0; i++)
      @(posedge clock);
    chk("byte count", host.n, s ? 32'h6 : 32'h2);
  endtask
  task stat(input logic [1:0] d, input logic f, p, r, e, n);
    logic [7:0] b;
    chk("status one", host.q[host.n - 2], {1'h0, d, 3'h0, f, p});
    b = {1'h0, at_cylinder_zero_flag[d], write_protect_flag[d], two_sided_flag[d],
      unit_ready_flag[d], r, e, n};
    chk("status two", host.q[host.n - 1], b);
    // Parity is enabled at start, so each status byte carries odd parity
    chk("parity one", host.par[host.n - 2], ~^host.q[host.n - 2]);
    chk("parity two", host.par[host.n - 1], ~^host.q[host.n - 1]);
  endtask
  task t_addr;
    {op_drive_select, op_is_rw, op_error_code} <= {2'h1, 1'h1, dssr_pkg::EC_DATA_CRC};
    {op_cylinder_number, op_head_number, op_sector_number} <= {11'h5a3, 4'h9, 6'h2d};
    run(2'h1, 1'h0, 1'h0, 1'h1);
    stat(2'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
    run(2'h1, 1'h1, 1'h1, 1'h0);
    chk("sense", {host.q[0], host.q[1], host.q[2], host.q[3]}, 32'h11396da3);
    stat(2'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
    wb(1'h0, dssr_pkg::REG_ERR_LOG);
    chk("error log", rd, 32'h1100);
    wb(1'h0, dssr_pkg::REG_LAST_ADDR);
    chk("last addr", rd, 32'h168e6d);
    wb(1'h0, dssr_pkg::REG_CTRL);
    chk("control", rd, 32'h1);
    wb(1'h0, 4'h2);
    chk("unmapped", rd, 32'h0);
  endtask
  task t_other;
    {op_drive_select, op_error_code, op_logical_sector} <= {2'h2, 6'h0, 21'h0f1234};
    {op_cylinder_number, op_head_number, op_sector_number} <= {11'h2f0, 4'h3, 6'h05};
    slow <= 4'h5;
    run(2'h2, 1'h0, 1'h0, 1'h1);
    stat(2'h2, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
    run(2'h1, 1'h1, 1'h0, 1'h0);
    chk("sense", {host.q[0], host.q[1], host.q[2], host.q[3]}, 32'h112f1234);
    stat(2'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0);
  endtask
  task t_codes;
    logic [5:0] c [30] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h06, 6'h11, 6'h12, 6'h13, 6'h14,
      6'h15, 6'h17, 6'h1c, 6'h1d, 6'h1e, 6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h27,
      6'h28, 6'h31, 6'h32, 6'h33, 6'h34, 6'h35, 6'h16, 6'h1f, 6'h1b};
    logic [31:0] e;
    // Non-transfer errors must leave the stored address alone
    for (int j = 0; j < 30; j++)
    begin
      {op_drive_select, op_is_rw, op_error_code} <= {3'h0, j < 27 ? c[j] : 6'h0};
      {op_late_ack, op_parity_err, op_deleted_mark} <= {j == 27, j == 28, j == 29};
      slow <= 4'(j % 4);
      run(2'h0, 1'h0, 1'h0, 1'h1);
      stat(2'h0, 1'h1, j == 28, 1'h0, 1'h0, 1'h0);
      run(2'h0, 1'h1, 1'h1, 1'h0);
      e = {2'h0, c[j], 24'h0385f0};
      chk("code", {host.q[0], host.q[1], host.q[2], host.q[3]}, e);
      stat(2'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
    end
  endtask
  task t_nd;
    @(posedge clock);
    {disk_changed, seen_q} <= {4'ha, 1'h0};
    @(posedge clock);
    disk_changed <= 4'h0;
    for (int k = 0; k < 3; k++)
    begin
      run(k == 2 ? 2'h1 : 2'h3, 1'h0, 1'h0, 1'h0);
      chk("recal", seen_q, k == 0);
      stat(k == 2 ? 2'h1 : 2'h3, 1'h1, 1'h0, 1'h0, 1'h0, k == 0);
      seen_q <= 1'h0;
    end
  endtask
  task t_rt;
    {op_deleted_mark, op_retried, op_corrected} <= 3'h3;
    run(2'h0, 1'h0, 1'h0, 1'h1);
    stat(2'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0);
  endtask
  initial
  begin
    {clock, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i, cmd_start, op_done,
      cmd_drive_select, cmd_is_sense, cmd_physical_addr_flag, cmd_finish, op_is_rw,
      op_drive_select, op_error_code, op_late_ack, op_parity_err, op_deleted_mark,
      op_retried, op_corrected, op_cylinder_number, op_head_number, op_sector_number,
      op_logical_sector, disk_changed, slow, seen_q} = '0;
    {unit_ready_flag, two_sided_flag, write_protect_flag, at_cylinder_zero_flag} = 16'h5c69;
    srst = 1'h1;
    repeat (10) @(posedge clock);
    srst <= 1'h0;
    wb(1'h1, dssr_pkg::REG_CTRL);
    t_addr;
    t_other;
    t_codes;
    t_nd;
    t_rt;
    stop_test;
  end
  initial
  begin
    #1000000;
    err_count++;
    stop_test;
  end
endmodule

// ===== verif/dssr_core_sva.sv
`timescale 1ns/10ps
module dssr_core_chk (
  input wire logic clock,
  input wire logic srst,
  input wire logic host_ack,
  input wire logic host_req,
  input wire logic [7:0] host_data_o,
  input wire logic host_data_oe,
  input wire logic command_status_phase,
  input wire logic host_out_dir,
  input wire logic controller_engaged,
  input wire logic final_msg
);
  logic [2:0] n_q;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // Data bytes of this command, so the status phase can be tied to the count
  always_ff @(posedge clock)
  begin
    if (srst || !controller_engaged)
      n_q <= 3'h0;
    else if (host_req && host_ack && !command_status_phase)
      n_q <= n_q + 3'h1;
  end
  req_hold_a: assert property (host_req && !host_ack |=> host_req)
    else $error("request dropped early");
  req_drop_a: assert property (host_req && host_ack |=> !host_req)
    else $error("request kept");
  data_hold_a: assert property (host_req && !host_ack |=> $stable(host_data_o))
    else $error("byte moved");
  msg_phase_a: assert property (final_msg |-> command_status_phase && host_out_dir)
    else $error("final byte outside status");
  data_drive_a: assert property (host_req |-> host_data_oe && host_out_dir)
    else $error("byte not driven");
  end_drop_a: assert property (final_msg && host_req && host_ack |=>
    !controller_engaged && !command_status_phase && !host_out_dir) else $error("no release");
  stat_fmt_a: assert property (command_status_phase && host_req && !final_msg |->
    host_data_o[7] == 1'h0 && host_data_o[4:2] == 3'h0) else $error("status one format");
  sense_cnt_a: assert property ($rose(command_status_phase) |->
    n_q == 3'h0 || n_q == 3'h4) else $error("sense byte count");
  sense_top_a: assert property (host_req && !command_status_phase && n_q == 3'h0 |->
    host_data_o[7:6] == 2'h0) else $error("sense byte one top");
  stat_due_a: assert property ($rose(controller_engaged) |->
    ##[1:300] command_status_phase) else $error("no status");
  cover property ($rose(command_status_phase) && n_q == 3'h4);
  cover property (final_msg && host_req && host_ack);
  cover property (host_req && host_ack && !command_status_phase);
endmodule
bind dssr_core dssr_core_chk chk (.clock, .srst, .host_ack, .host_req, .host_data_o, .host_data_oe,
  .command_status_phase, .host_out_dir, .controller_engaged, .final_msg);

// ===== verif/dssr_host_model.sv
`timescale 1ns/10ps
// Host adapter; slow sets how many cycles it sits on each request
module dssr_host_model (
  input wire logic clock,
  input wire logic srst,
  input wire logic [3:0] slow,
  input wire logic host_req,
  input wire logic [7:0] host_data_o,
  input wire logic host_parity_o,
  output logic host_ack = 1'h0
);
  logic [7:0] q [8];
  logic par [8];
  int n = 0;
  int w = 0;
  always @(posedge clock)
  begin
    if (srst)
      host_ack <= 1'h0;
    else if (host_ack)
    begin
      if (!host_req)
        host_ack <= 1'h0;
    end
    else if (host_req)
    begin
      w = w + 1;
      if (w > slow)
      begin
        host_ack <= 1'h1;
        q[n[2:0]] = host_data_o;
        par[n[2:0]] = host_parity_o;
        n = n + 1;
        w = 0;
      end
    end
  end
endmodule
